// ---- hdl/fsmc_ctrl.sv ----
// Purpose: Mode state machine: start-up, restart, fail-safe, reset output
// Assumes: mclk is the on-chip oscillator; rst_n is power-on
// Notes:   Operating-mode internals (normal, low power, flash) are
//          outside; this block only reports which one is selected.

// Notes on behaviour
// - Power-on starts in start-up state
// - System reset from normal, flash or low power returns to start-up
// - Record cause of each system reset
// - Wake from low-power or fail-safe restarts
// - Stretch reset per select bit
// - Hold reset low during stretch
// - Await watchdog init after release
// - Init success enters selected mode
// - Init failure enters restart state
// - Restart entry forces long stretch
// - Restart success enters normal only
// - Persistent fault or regulator fail in restart: fail-safe
// - Severe fault anywhere enters fail-safe
// - Leave fail-safe only on wake
// - Fail-safe wake accepted only with good oscillator
// - Restart delay before start-up
// - Fail-safe restart enables regulator, long stretch
// - Clocked from on-chip oscillator only
// - Controller drives reset and interrupt
// - Inhibit output floats until driven
// - Wake sampled continuous or cyclic
module fsmc_ctrl #(
  parameter int unsigned STRETCH_SHORT = fsmc_pkg::STRETCH_SHORT_CYC,
  parameter int unsigned STRETCH_LONG  = fsmc_pkg::STRETCH_LONG_CYC,
  parameter int unsigned RESTART_DLY   = fsmc_pkg::RESTART_CYC,
  parameter int unsigned WD_INIT       = fsmc_pkg::WD_INIT_CYC,
  parameter int unsigned WAKE_PERIOD   = fsmc_pkg::WAKE_PERIOD_CYC,
  parameter int unsigned WAKE_PULSE    = fsmc_pkg::WAKE_PULSE_CYC
) (
  // Clock and power-on reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Software control, same clock domain
  input  wire logic       reset_stretch_select,
  input  wire logic       stretch_select_we,
  input  wire logic       opmode_we,
  input  wire logic [2:0] opmode_code,
  input  wire logic       wd_init_ok,
  input  wire logic       sys_reset_req,
  input  wire logic       flash_entry_req,
  input  wire logic       lowpwr_req,
  input  wire logic       irq_req,
  input  wire logic       wake_cyclic,
  // Status from analog side and pins
  input  wire logic       severe_fault,
  input  wire logic       osc_ok,
  input  wire logic       supply_ok,
  input  wire logic       can_wake,
  input  wire logic       lin_wake,
  input  wire logic       wake_pin,
  // Outputs
  output logic            mcu_reset_out_low,
  output logic            mcu_irq_out_low,
  output logic            mcu_supply_regulator,
  output logic            inhibit_limphome_output,
  output logic            inhibit_limphome_oe,
  output logic            switched_highvolt_output,
  output logic [3:0]      reset_source,
  output logic [6:0]      mode_state,
  output logic            stretch_long_active
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial begin
    if (STRETCH_SHORT < 1 || STRETCH_LONG < STRETCH_SHORT ||
        RESTART_DLY < 1 || WD_INIT < 1 ||
        WAKE_PULSE < 1 || WAKE_PERIOD <= WAKE_PULSE) begin
      $error("fsmc_ctrl: bad timing parameters");
    end
  end

  localparam int CW = 32;

  // ****************************************************************
  // Wake pin synchroniser and sampling
  // ****************************************************************
  logic [2:0]    wsync_q, wsync_d;
  logic          wake_lvl_q, wake_lvl_d;
  logic [CW-1:0] wcnt_q, wcnt_d;
  logic          hv_q, hv_d;
  logic          wake_evt;
  logic          sample_now;

  always_comb begin
    wsync_d = {wsync_q[1:0], wake_pin};
    wcnt_d  = (wcnt_q >= CW'(WAKE_PERIOD - 1)) ? '0 : wcnt_q + 1'b1;
    hv_d       = wake_cyclic ? (wcnt_q < CW'(WAKE_PULSE)) : 1'b1;
    sample_now = wake_cyclic ? (wcnt_q == CW'(WAKE_PULSE - 1)) : 1'b1;
    wake_lvl_d = wake_lvl_q;
    if (sample_now && wsync_q[2] == wsync_q[1]) begin
      wake_lvl_d = wsync_q[2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wsync_q    <= 3'h7;
      wake_lvl_q <= 1'b1;
      wcnt_q     <= '0;
      hv_q       <= 1'b0;
    end else begin
      wsync_q    <= wsync_d;
      wake_lvl_q <= wake_lvl_d;
      wcnt_q     <= wcnt_d;
      hv_q       <= hv_d;
    end
  end

  // Falling edge of local wake, or bus wake
  assign wake_evt = (wake_lvl_q && !wake_lvl_d) || can_wake || lin_wake;

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  fsmc_pkg::fsmc_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          rel_q, rel_d;
  logic          sel_q, sel_d;
  logic          long_q, long_d;
  logic          flash_ok_q, flash_ok_d;
  logic [3:0]    src_q, src_d;
  logic          reg_q, reg_d;
  logic          inh_q, inh_d;
  logic          inh_oe_q, inh_oe_d;
  logic          irq_low_q, irq_low_d;
  logic          rst_out_q, rst_out_d;

  function automatic logic [CW-1:0] stretch_len(input logic lng);
    stretch_len = lng ? CW'(STRETCH_LONG) : CW'(STRETCH_SHORT);
  endfunction : stretch_len

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    rel_d      = rel_q;
    sel_d      = sel_q;
    long_d     = long_q;
    flash_ok_d = flash_ok_q;
    src_d      = src_q;
    reg_d      = reg_q;
    inh_d      = inh_q;
    inh_oe_d   = inh_oe_q;
    irq_low_d  = !(irq_req && st_q == fsmc_pkg::ST_NORMAL);
    if (stretch_select_we) begin
      sel_d = reset_stretch_select;
    end
    if (flash_entry_req) begin
      flash_ok_d = 1'b1;
    end

    if (severe_fault && st_q != fsmc_pkg::ST_FAILSAFE) begin
      st_d     = fsmc_pkg::ST_FAILSAFE;
      rel_d    = 1'b0;
      reg_d    = 1'b0;
      inh_d    = 1'b0;
      inh_oe_d = 1'b1;
    end else if (sys_reset_req &&
                 (st_q == fsmc_pkg::ST_NORMAL ||
                  st_q == fsmc_pkg::ST_FLASH ||
                  st_q == fsmc_pkg::ST_LOWPWR)) begin
      st_d  = fsmc_pkg::ST_STARTUP;
      src_d = flash_entry_req ? fsmc_pkg::RSRC_FLASH
                              : fsmc_pkg::RSRC_EXTERNAL;
      long_d = sel_q;
      cnt_d  = stretch_len(sel_q);
      rel_d  = 1'b0;
      reg_d  = 1'b1;
    end else begin
      case (st_q)
        fsmc_pkg::ST_STARTUP, fsmc_pkg::ST_RESTART: begin
          if (!rel_q) begin
            if (cnt_q <= 1) begin
              rel_d = 1'b1;
              cnt_d = CW'(WD_INIT);
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end else if (st_q == fsmc_pkg::ST_RESTART && !supply_ok) begin
            st_d = fsmc_pkg::ST_FAILSAFE;
            rel_d = 1'b0;
            reg_d = 1'b0;
            inh_d = 1'b0;
            inh_oe_d = 1'b1;
          end else if (wd_init_ok && opmode_we &&
                       (opmode_code == fsmc_pkg::OPMODE_NORMAL ||
                        opmode_code == fsmc_pkg::OPMODE_FLASH)) begin
            if (st_q == fsmc_pkg::ST_STARTUP && flash_ok_q &&
                opmode_code == fsmc_pkg::OPMODE_FLASH) begin
              st_d = fsmc_pkg::ST_FLASH;
            end else begin
              st_d = fsmc_pkg::ST_NORMAL;
            end
            // Arming in the same cycle wins over the clear
            flash_ok_d = flash_entry_req;
            inh_d      = 1'b1;
            inh_oe_d   = 1'b1;
          end else if (cnt_q <= 1) begin
            rel_d = 1'b0;
            src_d = fsmc_pkg::RSRC_WD_INIT;
            if (st_q == fsmc_pkg::ST_STARTUP) begin
              st_d   = fsmc_pkg::ST_RESTART;
              long_d = 1'b1;
              cnt_d  = CW'(STRETCH_LONG);
            end else begin
              st_d     = fsmc_pkg::ST_FAILSAFE;
              reg_d    = 1'b0;
              inh_d    = 1'b0;
              inh_oe_d = 1'b1;
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        fsmc_pkg::ST_NORMAL, fsmc_pkg::ST_FLASH: begin
          if (lowpwr_req) begin
            st_d = fsmc_pkg::ST_LOWPWR;
          end
        end
        fsmc_pkg::ST_LOWPWR: begin
          if (wake_evt) begin
            st_d   = fsmc_pkg::ST_STARTUP;
            src_d  = fsmc_pkg::RSRC_WAKE;
            long_d = sel_q;
            cnt_d  = stretch_len(sel_q);
            rel_d  = 1'b0;
            reg_d  = 1'b1;
          end
        end
        fsmc_pkg::ST_FAILSAFE: begin
          if (wake_evt && osc_ok && !severe_fault) begin
            st_d  = fsmc_pkg::ST_RETDLY;
            cnt_d = CW'(RESTART_DLY);
          end
        end
        fsmc_pkg::ST_RETDLY: begin
          if (cnt_q <= 1) begin
            st_d   = fsmc_pkg::ST_STARTUP;
            src_d  = fsmc_pkg::RSRC_FAILSAFE;
            reg_d  = 1'b1;
            long_d = 1'b1;
            cnt_d  = CW'(STRETCH_LONG);
            rel_d  = 1'b0;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default: begin
          st_d = fsmc_pkg::ST_STARTUP;
        end
      endcase
    end
    rst_out_d = rel_d || st_d == fsmc_pkg::ST_NORMAL ||
                st_d == fsmc_pkg::ST_FLASH || st_d == fsmc_pkg::ST_LOWPWR;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= fsmc_pkg::ST_STARTUP;
      cnt_q      <= CW'(STRETCH_SHORT);
      rel_q      <= 1'b0;
      sel_q      <= fsmc_pkg::STRETCH_SEL_RST;
      long_q     <= 1'b0;
      flash_ok_q <= 1'b0;
      src_q      <= fsmc_pkg::RSRC_POWER_ON;
      reg_q      <= 1'b1;
      inh_q      <= 1'b0;
      inh_oe_q   <= 1'b0;
      irq_low_q  <= 1'b1;
      rst_out_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      rel_q      <= rel_d;
      sel_q      <= sel_d;
      long_q     <= long_d;
      flash_ok_q <= flash_ok_d;
      src_q      <= src_d;
      reg_q      <= reg_d;
      inh_q      <= inh_d;
      inh_oe_q   <= inh_oe_d;
      irq_low_q  <= irq_low_d;
      rst_out_q  <= rst_out_d;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign mcu_reset_out_low        = rst_out_q;
  assign mcu_irq_out_low          = irq_low_q;
  assign mcu_supply_regulator     = reg_q;
  assign inhibit_limphome_output  = inh_q;
  assign inhibit_limphome_oe      = inh_oe_q;
  assign switched_highvolt_output = hv_q;
  assign reset_source             = src_q;
  assign mode_state               = st_q;
  assign stretch_long_active      = long_q;

endmodule : fsmc_ctrl

// ---- hdl/fsmc_pkg.sv ----
// Purpose: Constants and types for the fail-safe start-up mode controller
// Assumes: 125 MHz mclk, times in microseconds
// Notes:   Reset source codes and time figures are plain defaults
package fsmc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned T_STRETCH_SHORT_US = 2000;
  localparam int unsigned T_STRETCH_LONG_US  = 20000;
  localparam int unsigned T_RESTART_US    = 100;
  localparam int unsigned T_WD_INIT_US    = 250000;
  localparam int unsigned T_WAKE_PERIOD_US = 20000;
  localparam int unsigned T_WAKE_PULSE_US  = 100;
  localparam int unsigned STRETCH_SHORT_CYC = T_STRETCH_SHORT_US * CLK_MHZ;
  localparam int unsigned STRETCH_LONG_CYC  = T_STRETCH_LONG_US * CLK_MHZ;
  localparam int unsigned RESTART_CYC       = T_RESTART_US * CLK_MHZ;
  localparam int unsigned WD_INIT_CYC       = T_WD_INIT_US * CLK_MHZ;
  localparam int unsigned WAKE_PERIOD_CYC   = T_WAKE_PERIOD_US * CLK_MHZ;
  localparam int unsigned WAKE_PULSE_CYC    = T_WAKE_PULSE_US * CLK_MHZ;

  // ****************************************************************
  // Reset values and mode codes
  // ****************************************************************
  localparam logic       STRETCH_SEL_RST = 1'b0;
  localparam logic [2:0] OPMODE_FLASH    = 3'h3;
  localparam logic [2:0] OPMODE_NORMAL   = 3'h5;

  // Reset source codes
  localparam logic [3:0] RSRC_POWER_ON   = 4'h0;
  localparam logic [3:0] RSRC_EXTERNAL   = 4'h1;
  localparam logic [3:0] RSRC_WAKE       = 4'h2;
  localparam logic [3:0] RSRC_WD_INIT    = 4'h3;
  localparam logic [3:0] RSRC_FAILSAFE   = 4'h4;
  localparam logic [3:0] RSRC_FLASH      = 4'h6;

  typedef enum logic [6:0] {
    ST_STARTUP  = 7'h01,
    ST_RESTART  = 7'h02,
    ST_NORMAL   = 7'h04,
    ST_FLASH    = 7'h08,
    ST_LOWPWR   = 7'h10,
    ST_FAILSAFE = 7'h20,
    ST_RETDLY   = 7'h40
  } fsmc_state_t;

endpackage : fsmc_pkg

// ---- testbench/fsmc_ctrl_checker.sv ----
// Purpose: Port assertions for the mode controller
// Assumes: Bits of mode_state: 0 start-up, 1 restart, 2 normal,
//          3 flash, 4 low power, 5 fail-safe, 6 restart delay
// Notes:   Fixed counts match the shortened bench parameters
module fsmc_ctrl_checker #(
  parameter int unsigned STRETCH_LONG = 8
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Watched input
  input wire logic       severe_fault,
  // Watched outputs
  input wire logic       mcu_reset_out_low,
  input wire logic       mcu_supply_regulator,
  input wire logic [3:0] reset_source,
  input wire logic [6:0] mode_state,
  input wire logic       stretch_long_active
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG_MAX = STRETCH_LONG + 4;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Mode sequencing
  // ****************************************************************
  enter_hold_a: assert property (
    $rose(mode_state[0]) |-> (!mcu_reset_out_low)[*4]
      ##[1:LONG_MAX] mcu_reset_out_low) else $error("stretch wrong");
  long_hold_a: assert property (
    $rose(mode_state[0]) && stretch_long_active
      |-> (!mcu_reset_out_low)[*8]) else $error("long stretch short");
  no_early_mode_a: assert property (
    mode_state[0] && !mcu_reset_out_low |=> !mode_state[2]
      && !mode_state[3]) else $error("mode before release");
  restart_long_a: assert property (
    $rose(mode_state[1]) |-> ##[0:1] stretch_long_active)
    else $error("restart not long");
  restart_flash_a: assert property (
    mode_state[1] |=> !mode_state[3]) else $error("flash from restart");
  restart_bound_a: assert property (
    $rose(mode_state[1]) |-> ##[1:40] !mode_state[1])
    else $error("restart stuck");
  fault_entry_a: assert property (
    severe_fault |=> mode_state[5] && !mcu_reset_out_low)
    else $error("fault not fail-safe");
  failsafe_exit_a: assert property (
    mode_state[5] |=> mode_state[5] || mode_state[6])
    else $error("bad fail-safe exit");
  retdly_len_a: assert property (
    $rose(mode_state[6]) |-> (mode_state[6])[*3] ##1 mode_state[0])
    else $error("restart delay wrong");
  retdly_exit_a: assert property (
    $rose(mode_state[0]) && $past(mode_state[6]) |-> mcu_supply_regulator
      && stretch_long_active && reset_source == fsmc_pkg::RSRC_FAILSAFE)
    else $error("fail-safe restart wrong");
endmodule : fsmc_ctrl_checker

bind fsmc_ctrl fsmc_ctrl_checker #(.STRETCH_LONG(STRETCH_LONG)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .severe_fault(severe_fault),
  .mcu_reset_out_low(mcu_reset_out_low),
  .mcu_supply_regulator(mcu_supply_regulator),
  .reset_source(reset_source), .mode_state(mode_state),
  .stretch_long_active(stretch_long_active));

// ---- testbench/fsmc_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the mode controller
// Assumes: Counts shortened: stretch 4 and 8, delay 3, init 10
// Notes:   Host model answers the watchdog; bench drives the rest
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end \
end
module fsmc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  localparam int L = 8;
  localparam int R = 3;
  logic       mclk, rst_n, reset_stretch_select, stretch_select_we;
  logic       sys_reset_req, flash_entry_req, lowpwr_req, irq_req;
  logic       wake_cyclic, severe_fault, osc_ok, supply_ok, can_wake;
  logic       lin_wake, wake_pin, wd_init_ok, opmode_we, p;
  logic       mcu_reset_out_low, mcu_irq_out_low, mcu_supply_regulator;
  logic       inhibit_limphome_output, inhibit_limphome_oe;
  logic       switched_highvolt_output, stretch_long_active;
  logic [2:0] opmode_code, code;
  logic [3:0] reset_source;
  logic [6:0] mode_state;
  logic [7:0] dly;
  int         mismatches, n_compared, cycles, r, m_len;

  fsmc_ctrl #(.STRETCH_SHORT(S), .STRETCH_LONG(L), .RESTART_DLY(R),
    .WD_INIT(10), .WAKE_PERIOD(8), .WAKE_PULSE(2)) dut (
    .mclk, .rst_n, .reset_stretch_select, .stretch_select_we, .opmode_we,
    .opmode_code, .wd_init_ok, .sys_reset_req, .flash_entry_req,
    .lowpwr_req, .irq_req, .wake_cyclic, .severe_fault, .osc_ok,
    .supply_ok, .can_wake, .lin_wake, .wake_pin, .mcu_reset_out_low,
    .mcu_irq_out_low, .mcu_supply_regulator, .inhibit_limphome_output,
    .inhibit_limphome_oe, .switched_highvolt_output, .reset_source,
    .mode_state, .stretch_long_active);
  fsmc_host_model host (.mclk, .rst_n, .mcu_reset_out_low,
    .reply_dly(dly), .reply_code(code), .wd_init_ok, .opmode_we,
    .opmode_code);

  always #4 mclk = ~mclk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic go(input logic [6:0] st);
    for (int n = 0; n < 60 && mode_state !== st; n++) cyc(1);
    `CHK("state", st, mode_state)
  endtask : go
  task automatic hold_low(input int e);
    int n;
    for (n = 0; n < 40 && mcu_reset_out_low !== 1'b1; n++) cyc(1);
    `CHK("stretch", e, n)
  endtask : hold_low
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      stop_test();
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {mclk, rst_n, reset_stretch_select, stretch_select_we} = 4'h0;
    {sys_reset_req, flash_entry_req, lowpwr_req, irq_req} = 4'h0;
    {wake_cyclic, severe_fault, can_wake, lin_wake} = 4'h0;
    {osc_ok, supply_ok, wake_pin} = 3'h7;
    code = fsmc_pkg::OPMODE_NORMAL;
    void'($urandom(39284));
    dly = 8'($urandom_range(4, 1));
    m_len = S;
    cyc(3);
    rst_n = 1'b1;
    `CHK("src", fsmc_pkg::RSRC_POWER_ON, reset_source)
    `CHK("long", 1'b0, stretch_long_active)
    `CHK("inh oe", 1'b0, inhibit_limphome_oe)
    go(fsmc_pkg::ST_STARTUP);
    hold_low(m_len);
    go(fsmc_pkg::ST_NORMAL);
    pulse(sys_reset_req);
    go(fsmc_pkg::ST_STARTUP);
    hold_low(m_len);
    go(fsmc_pkg::ST_NORMAL);
    cyc(5);
    `CHK("src", fsmc_pkg::RSRC_EXTERNAL, reset_source)
    done("reset");
    for (int i = 0; i < 3; i++) begin
      code = (i == 1) ? fsmc_pkg::OPMODE_NORMAL : fsmc_pkg::OPMODE_FLASH;
      flash_entry_req = (i < 2);
      pulse(sys_reset_req);
      flash_entry_req = 1'b0;
      go(fsmc_pkg::ST_STARTUP);
      `CHK("src", i < 2 ? fsmc_pkg::RSRC_FLASH : fsmc_pkg::RSRC_EXTERNAL, reset_source)
      go(i == 0 ? fsmc_pkg::ST_FLASH : fsmc_pkg::ST_NORMAL);
    end
    done("flash");
    m_len = L;
    dly = 8'hFF;
    flash_entry_req = 1'b1;
    pulse(sys_reset_req);
    flash_entry_req = 1'b0;
    go(fsmc_pkg::ST_RESTART);
    dly = 8'($urandom_range(4, 1));
    `CHK("long", 1'b1, stretch_long_active)
    hold_low(m_len);
    go(fsmc_pkg::ST_NORMAL);
    dly = 8'hFF;
    pulse(sys_reset_req);
    go(fsmc_pkg::ST_RESTART);
    go(fsmc_pkg::ST_FAILSAFE);
    `CHK("reg", 1'b0, mcu_supply_regulator)
    `CHK("inh oe", 1'b1, inhibit_limphome_oe)
    osc_ok = 1'b0;
    pulse(can_wake);
    cyc(6);
    `CHK("state", fsmc_pkg::ST_FAILSAFE, mode_state)
    osc_ok = 1'b1;
    dly = 8'h01;
    code = fsmc_pkg::OPMODE_NORMAL;
    done("restart");
    for (int k = 0; k < 3; k++) begin
      if (k == 0) pulse(can_wake);
      else if (k == 1) pulse(lin_wake);
      else wake_pin = 1'b0;
      go(fsmc_pkg::ST_RETDLY);
      wake_pin = 1'b1;
      go(fsmc_pkg::ST_STARTUP);
      `CHK("src", fsmc_pkg::RSRC_FAILSAFE, reset_source)
      `CHK("reg", 1'b1, mcu_supply_regulator)
      hold_low(m_len);
      go(fsmc_pkg::ST_NORMAL);
      pulse(severe_fault);
      go(fsmc_pkg::ST_FAILSAFE);
    end
    done("fail-safe");
    pulse(can_wake);
    go(fsmc_pkg::ST_NORMAL);
    `CHK("inh oe", 1'b1, inhibit_limphome_oe)
    `CHK("inh", 1'b1, inhibit_limphome_output)
    irq_req = 1'b1;
    cyc(2);
    `CHK("irq", 1'b0, mcu_irq_out_low)
    irq_req = 1'b0;
    pulse(lowpwr_req);
    go(fsmc_pkg::ST_LOWPWR);
    cyc(2);
    `CHK("hv", 1'b1, switched_highvolt_output)
    wake_cyclic = 1'b1;
    r = 0;
    for (int c = 0; c < 24; c++) begin
      p = switched_highvolt_output;
      cyc(1);
      r += (p === 1'b0 && switched_highvolt_output === 1'b1);
    end
    `CHK("hv pulses", 1'b1, r >= 2 && r <= 4)
    wake_pin = 1'b0;
    cyc(10);
    wake_pin = 1'b1;
    go(fsmc_pkg::ST_STARTUP);
    `CHK("src", fsmc_pkg::RSRC_WAKE, reset_source)
    go(fsmc_pkg::ST_NORMAL);
    done("low power");
    dly = 8'hFF;
    pulse(sys_reset_req);
    go(fsmc_pkg::ST_RESTART);
    supply_ok = 1'b0;
    hold_low(m_len);
    cyc(1);
    `CHK("state", fsmc_pkg::ST_FAILSAFE, mode_state)
    supply_ok = 1'b1;
    dly = 8'h01;
    pulse(lin_wake);
    go(fsmc_pkg::ST_NORMAL);
    done("supply");
    reset_stretch_select = 1'b1;
    pulse(stretch_select_we);
    reset_stretch_select = 1'b0;
    pulse(sys_reset_req);
    go(fsmc_pkg::ST_STARTUP);
    `CHK("long", 1'b1, stretch_long_active)
    hold_low(m_len);
    done("select");
    stop_test();
  end
endmodule : fsmc_ctrl_tb_top

// ---- testbench/fsmc_host_model.sv ----
// Purpose: Host microcontroller answering the watchdog at start-up
// Assumes: Same clock as the controller; delay chosen by the bench
// Notes:   Delay 8'hFF means the host never initialises the watchdog
module fsmc_host_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // From controller and bench
  input  wire logic       mcu_reset_out_low,
  input  wire logic [7:0] reply_dly,
  input  wire logic [2:0] reply_code,
  // To controller
  output logic            wd_init_ok,
  output logic            opmode_we,
  output logic [2:0]      opmode_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // ****************************************************************
  // Host start-up
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= 8'h00;
      wd_init_ok  <= 1'b0;
      opmode_we   <= 1'b0;
      opmode_code <= 3'h0;
    end else begin
      opmode_we   <= 1'b0;
      // Outside a write the code alternates between its inverse and the last written code
      opmode_code <= ~opmode_code;
      if (!mcu_reset_out_low) begin
        cnt_q      <= 8'h00;
        wd_init_ok <= 1'b0;
      end else if (cnt_q != 8'hFF) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == reply_dly) begin
          wd_init_ok  <= 1'b1;
          opmode_we   <= 1'b1;
          opmode_code <= reply_code;
        end
      end
    end
  end
endmodule : fsmc_host_model
